// file: verilog/pin_mux_pkg.sv
package pin_mux_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FUN_W = 3;
	localparam int STRAP_W = 4;

	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] IND_CFG_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] GPIO_CFG_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] GPIO_DATA_DIR_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] STRAP_STATUS_OFF = 8'h0C;
	localparam logic [ADDR_W-1:0] PIN_STATUS_OFF = 8'h10;

	// indicator_config_reg fields
	localparam int IND_EN_BIT = 0;
	localparam int IND_FUN_LSB = 8;
	// gpio config / data-direction fields
	localparam int GPIO_OD_BIT = 0;
	localparam int GPIO_DATA_BIT = 0;
	localparam int GPIO_DIR_BIT = 8;
	// strap status fields
	localparam int STRAP_LSB = 0;
	localparam int MODE_LSB = 4;
	localparam int STRAP_VALID_BIT = 8;
	// pin status fields
	localparam int PST_IND_BIT = 0;
	localparam int PST_OE_BIT = 1;
	localparam int PST_OUT_BIT = 2;
	localparam int PST_IN_BIT = 3;

	// function codes with this bit set select the open buffer
	localparam logic [FUN_W-1:0] FUN_OPEN_MASK = 3'h4;

	// reset values
	localparam logic IND_EN_RST = 1'h0;
	localparam logic [FUN_W-1:0] IND_FUN_RST = 3'h0;
	localparam logic GPIO_OD_RST = 1'h0;
	localparam logic GPIO_DATA_RST = 1'h0;
	localparam logic GPIO_DIR_RST = 1'h0;
	localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pad_drive_t;

	typedef enum {CAP_ARMED, CAP_HELD} cap_state_t;

	typedef enum {
		ROLE_IND_PP, ROLE_IND_OPEN, ROLE_GPIO_PP, ROLE_GPIO_OD, ROLE_GPIO_IN
	} pin_role_t;

endpackage : pin_mux_pkg

// file: verilog/led_gpio_strap_pin_mux.sv
`timescale 1ns/1ps
// Summary of operation
// - enable bit set: pin is indicator output
// - function field picks push-pull or open buffer
// - open buffer polarity follows captured strap 0
// - enable bit clear: pin is general I/O
// - general I/O: push-pull, open-drain or input
// - four straps together give host bus mode
// - straps latched after reset, held until next
module led_gpio_strap_pin_mux (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire pin_mux_pkg::reg_req_t req_i,
	output logic [pin_mux_pkg::DATA_W-1:0] rdata_o,
	input wire logic indicator_on_i,
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe_o,
	input wire logic [pin_mux_pkg::STRAP_W-1:1] host_cfg_strap_i,
	output logic [pin_mux_pkg::STRAP_W-1:0] host_bus_mode_o,
	output logic strap_valid_o
);
	import pin_mux_pkg::*;

	// configuration registers
	logic ind_en_q;
	logic [FUN_W-1:0] ind_fun_q;
	logic gpio_od_q;
	logic gpio_data_q;
	logic gpio_dir_q;

	// strap capture
	cap_state_t cap_q;
	cap_state_t cap_d;
	logic [STRAP_W-1:0] strap_q;
	logic [STRAP_W-1:0] mode_q;

	// pin input conditioning
	logic pad_s_q;
	logic pad_in_q;

	// pin drive
	pin_role_t role;
	pad_drive_t drive_d;
	pad_drive_t drive_q;

	// read path
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;

	function automatic logic hit(input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] off);
		hit = (addr == off);
	endfunction : hit

	function automatic logic fun_is_open(input logic [FUN_W-1:0] fun);
		fun_is_open = |(fun & FUN_OPEN_MASK);
	endfunction : fun_is_open

	logic wr_ind;
	logic wr_gcfg;
	logic wr_gdd;

	assign wr_ind = req_i.wr && hit(req_i.addr, IND_CFG_OFF);
	assign wr_gcfg = req_i.wr && hit(req_i.addr, GPIO_CFG_OFF);
	assign wr_gdd = req_i.wr && hit(req_i.addr, GPIO_DATA_DIR_OFF);

	// indicator configuration register
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			ind_en_q <= IND_EN_RST;
			ind_fun_q <= IND_FUN_RST;
		end else if (wr_ind) begin
			ind_en_q <= req_i.wdata[IND_EN_BIT];
			ind_fun_q <= req_i.wdata[IND_FUN_LSB +: FUN_W];
		end
	end

	// general I/O configuration register
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			gpio_od_q <= GPIO_OD_RST;
		end else if (wr_gcfg) begin
			gpio_od_q <= req_i.wdata[GPIO_OD_BIT];
		end
	end

	// general I/O data and direction register
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			gpio_data_q <= GPIO_DATA_RST;
			gpio_dir_q <= GPIO_DIR_RST;
		end else if (wr_gdd) begin
			gpio_data_q <= req_i.wdata[GPIO_DATA_BIT];
			gpio_dir_q <= req_i.wdata[GPIO_DIR_BIT];
		end
	end

	// capture runs once, in the first cycle after reset release
	always_comb begin
		cap_d = cap_q;
		unique case (cap_q)
			CAP_ARMED: begin
				cap_d = CAP_HELD;
			end
			CAP_HELD: begin
				cap_d = CAP_HELD;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			cap_q <= CAP_ARMED;
		end else begin
			cap_q <= cap_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			strap_q <= STRAP_RST;
		end else if (cap_q == CAP_ARMED) begin
			strap_q <= {host_cfg_strap_i, pad_i};
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			mode_q <= STRAP_RST;
			strap_valid_o <= 1'h0;
		end else begin
			mode_q <= strap_q;
			strap_valid_o <= (cap_q == CAP_HELD);
		end
	end

	assign host_bus_mode_o = mode_q;

	// input filter: level moves only after two equal samples
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			pad_s_q <= 1'h0;
			pad_in_q <= 1'h0;
		end else begin
			pad_s_q <= pad_i;
			if (pad_i == pad_s_q) begin
				pad_in_q <= pad_s_q;
			end
		end
	end

	// role of the shared pin
	always_comb begin
		if (ind_en_q) begin
			if (fun_is_open(ind_fun_q)) begin
				role = ROLE_IND_OPEN;
			end else begin
				role = ROLE_IND_PP;
			end
		end else if (!gpio_dir_q) begin
			role = ROLE_GPIO_IN;
		end else if (gpio_od_q) begin
			role = ROLE_GPIO_OD;
		end else begin
			role = ROLE_GPIO_PP;
		end
	end

	// pin drive per role
	always_comb begin
		drive_d.out = 1'h0;
		drive_d.oe = 1'h0;
		unique case (role)
			ROLE_IND_PP: begin
				drive_d.out = indicator_on_i ^ strap_q[0];
				drive_d.oe = 1'h1;
			end
			ROLE_IND_OPEN: begin
				drive_d.out = ~strap_q[0];
				drive_d.oe = indicator_on_i;
			end
			ROLE_GPIO_PP: begin
				drive_d.out = gpio_data_q;
				drive_d.oe = 1'h1;
			end
			ROLE_GPIO_OD: begin
				drive_d.out = 1'h0;
				drive_d.oe = ~gpio_data_q;
			end
			ROLE_GPIO_IN: begin
				drive_d.out = 1'h0;
				drive_d.oe = 1'h0;
			end
		endcase
		// keep the pin released until strap 0 is taken
		if (cap_q != CAP_HELD) begin
			drive_d.oe = 1'h0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	assign pad_o = drive_q.out;
	assign pad_oe_o = drive_q.oe;

	// read mux, answered in the next cycle
	always_comb begin
		rdata_d = '0;
		if (req_i.rd) begin
			if (hit(req_i.addr, IND_CFG_OFF)) begin
				rdata_d[IND_EN_BIT] = ind_en_q;
				rdata_d[IND_FUN_LSB +: FUN_W] = ind_fun_q;
			end else if (hit(req_i.addr, GPIO_CFG_OFF)) begin
				rdata_d[GPIO_OD_BIT] = gpio_od_q;
			end else if (hit(req_i.addr, GPIO_DATA_DIR_OFF)) begin
				// data bit reads the pin when it is an input
				rdata_d[GPIO_DATA_BIT] = gpio_dir_q ? gpio_data_q : pad_in_q;
				rdata_d[GPIO_DIR_BIT] = gpio_dir_q;
			end else if (hit(req_i.addr, STRAP_STATUS_OFF)) begin
				rdata_d[STRAP_LSB +: STRAP_W] = strap_q;
				rdata_d[MODE_LSB +: STRAP_W] = mode_q;
				rdata_d[STRAP_VALID_BIT] = strap_valid_o;
			end else if (hit(req_i.addr, PIN_STATUS_OFF)) begin
				rdata_d[PST_IND_BIT] = ind_en_q;
				rdata_d[PST_OE_BIT] = drive_q.oe;
				rdata_d[PST_OUT_BIT] = drive_q.out;
				rdata_d[PST_IN_BIT] = pad_in_q;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

endmodule : led_gpio_strap_pin_mux

// file: testbench/pin_mux_chk.sv
`timescale 1ns/1ps
module pin_mux_chk (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire pin_mux_pkg::reg_req_t req_i,
	input wire logic indicator_on_i,
	input wire logic pad_o,
	input wire logic pad_oe_o,
	input wire logic [pin_mux_pkg::STRAP_W-1:1] host_cfg_strap_i,
	input wire logic [pin_mux_pkg::STRAP_W-1:0] host_bus_mode_o,
	input wire logic strap_valid_o
);
	import pin_mux_pkg::*;
	logic [3:0] ind_q;
	logic ind_use;
	// shadow of indicator enable and function
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			ind_q <= 4'h0;
		end else if (req_i.wr && req_i.addr == IND_CFG_OFF) begin
			ind_q <= {req_i.wdata[10:8], req_i.wdata[0]};
		end
	end
	assign ind_use = strap_valid_o && ind_q[0];
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	a_reset_quiet:
	assert property (disable iff (1'b0)
		!reset_n_i |=> !pad_oe_o && !strap_valid_o) else $error("reset drive");
	a_no_early:
	assert property (!strap_valid_o |-> !pad_oe_o) else $error("early drive");
	a_strap_cap:
	assert property ($rose(strap_valid_o) |->
		host_bus_mode_o[3:1] == $past(host_cfg_strap_i, 2)) else $error("mode");
	a_strap_hold:
	assert property (strap_valid_o && $past(strap_valid_o) |->
		$stable(host_bus_mode_o)) else $error("mode moved");
	a_ind_open:
	assert property (ind_use && ind_q[3] && indicator_on_i |=>
		pad_oe_o && pad_o != host_bus_mode_o[0]) else $error("open lit");
	a_open_off:
	assert property (ind_use && ind_q[3] && !indicator_on_i |=> !pad_oe_o)
		else $error("open unlit");
	a_ind_pp:
	assert property (ind_use && !ind_q[3] |=> pad_oe_o
		&& pad_o == ($past(indicator_on_i) ^ host_bus_mode_o[0]))
		else $error("push-pull");
endmodule : pin_mux_chk
bind led_gpio_strap_pin_mux pin_mux_chk u_chk (.clock_i, .reset_n_i, .req_i,
	.indicator_on_i, .pad_o, .pad_oe_o, .host_cfg_strap_i, .host_bus_mode_o,
	.strap_valid_o);

// file: testbench/pin_board.sv
`timescale 1ns/1ps
module pin_board (
	input wire logic drv_i,
	input wire logic oe_i,
	input wire logic ext_oe_i,
	input wire logic ext_i,
	input wire logic strap0_i,
	output logic pad_o
);
	// strap resistor sets the level when nobody drives
	assign pad_o = oe_i ? drv_i : (ext_oe_i ? ext_i : strap0_i);
endmodule : pin_board

// file: testbench/test_led_gpio_strap_pin_mux.sv
`timescale 1ns/1ps
module test_led_gpio_strap_pin_mux;
	import pin_mux_pkg::*;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	reg_req_t req = '0;
	logic [31:0] rdata;
	logic ind_on = 1'b0;
	logic pad_i;
	logic pad_o;
	logic pad_oe;
	logic [3:1] strap = 3'h0;
	logic [3:0] mode;
	logic valid;
	logic s0 = 1'b0;
	logic ext_oe = 1'b0;
	logic ext = 1'b0;
	int err_count = 0;
	int n_compared = 0;
	led_gpio_strap_pin_mux u_dut (.clock_i, .reset_n_i, .req_i(req),
		.rdata_o(rdata), .indicator_on_i(ind_on), .pad_i, .pad_o,
		.pad_oe_o(pad_oe), .host_cfg_strap_i(strap),
		.host_bus_mode_o(mode), .strap_valid_o(valid));
	pin_board u_brd (.drv_i(pad_o), .oe_i(pad_oe), .ext_oe_i(ext_oe),
		.ext_i(ext), .strap0_i(s0), .pad_o(pad_i));
	initial begin
		forever #20 clock_i = ~clock_i;
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s exp %0h got %0h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock_i);
		req.wr <= 1'b0;
		@(posedge clock_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock_i);
		req.rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
		@(posedge clock_i);
	endtask : rd
	task automatic rst(input logic [3:0] s);
		strap <= s[3:1];
		s0 <= s[0];
		reset_n_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		chk("mode", 32'(s), 32'(mode));
		chk("valid", 32'h1, 32'(valid));
		@(posedge clock_i);
	endtask : rst
	task automatic pchk(input logic oe, input logic v);
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		chk("pad_oe", 32'(oe), 32'(pad_oe));
		if (oe) begin
			chk("pad", 32'(v), 32'(pad_o));
		end
		@(posedge clock_i);
	endtask : pchk
	task automatic t_straps();
		rst(4'hA);
		rd(STRAP_STATUS_OFF, 32'h1AA);
		wr(STRAP_STATUS_OFF, 32'h0);
		strap <= 3'h2;
		s0 <= 1'b1;
		rd(STRAP_STATUS_OFF, 32'h1AA);
		rd(8'h44, 32'h0);
	endtask : t_straps
	task automatic t_ind(input logic [3:0] s);
		rst(s);
		for (int f = 0; f < 8; f++) begin
			wr(IND_CFG_OFF, 32'h1 | (32'(f) << IND_FUN_LSB));
			for (int on = 0; on < 2; on++) begin
				ind_on <= on[0];
				pchk(!f[2] || on[0], f[2] ? !s[0] : on[0] ^ s[0]);
			end
		end
		rd(IND_CFG_OFF, 32'h701);
		rd(PIN_STATUS_OFF, 32'h3 | (s[0] ? 32'h0 : 32'hC));
		ind_on <= 1'b0;
	endtask : t_ind
	task automatic t_gpio();
		wr(IND_CFG_OFF, 32'h0);
		ext_oe <= 1'b1;
		pchk(1'b0, 1'b0);
		rd(GPIO_DATA_DIR_OFF, 32'h0);
		ext <= 1'b1;
		pchk(1'b0, 1'b0);
		repeat (2) @(posedge clock_i);
		rd(GPIO_DATA_DIR_OFF, 32'h1);
		ext_oe <= 1'b0;
		wr(GPIO_DATA_DIR_OFF, 32'h101);
		pchk(1'b1, 1'b1);
		wr(GPIO_CFG_OFF, 32'h1);
		pchk(1'b0, 1'b0);
		wr(GPIO_DATA_DIR_OFF, 32'h100);
		pchk(1'b1, 1'b0);
		rd(GPIO_CFG_OFF, 32'h1);
		rd(GPIO_DATA_DIR_OFF, 32'h100);
		rd(PIN_STATUS_OFF, 32'h2);
	endtask : t_gpio
	task automatic final_report();
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (3000) @(posedge clock_i);
		err_count++;
		final_report();
	end
	initial begin
		t_straps();
		t_ind(4'h5);
		t_ind(4'hA);
		t_gpio();
		final_report();
	end
endmodule : test_led_gpio_strap_pin_mux
